// ==== ssm_safing_top.sv ====
// Safing front end: bus monitor, analog holding register and arming outputs
module ssm_safing_top #(
  parameter int unsigned ARM_DWELL_CYC = ssm_pkg::ARM_DWELL_CYC_DEF
) (
  // System clock and reset
  input  wire logic                       clk_sys_i,
  input  wire logic                       sys_rst_i,
  // Serial bus
  input  wire logic                       spi_sck_i,
  input  wire logic                       spi_cs_n_i,
  input  wire logic [2:0]                 mon_cs_n_i,
  input  wire logic                       spi_si_i,
  input  wire logic                       mon_miso_i,
  output logic                            spi_so_o,
  output logic                            spi_so_oe_o,
  // Converter samples
  input  wire logic [ssm_pkg::ADC_W-1:0]  adc_data_i,
  input  wire logic                       adc_valid_i,
  // Control pins
  input  wire logic                       self_test_inhibit_i,
  input  wire logic                       arm_lockout_i,
  input  wire logic                       aux_comm_line_i,
  // Arming outputs and analog holding register
  output logic                            fire_enable_o,
  output logic                            fire_enable_oe_o,
  output logic                            fire_inhibit_out_o,
  output logic                            fire_inhibit_out_oe_o,
  output logic [ssm_pkg::ADC_W-1:0]       analog_hold_o
);

  localparam int unsigned SYNC_N   = 5;
  localparam int unsigned FILT_W   = ssm_pkg::ADC_W + ssm_pkg::FILT_FRAC;
  localparam logic [15:0] SU_LAST  = 16'(ssm_pkg::STARTUP_CYC - 1);
  localparam logic [31:0] DWELL_LD = 32'(ARM_DWELL_CYC - 1);

  ssm_pkg::ssm_mon_word_t cap;
  ssm_pkg::ssm_state_t    state_q;
  ssm_pkg::ssm_state_t    state_d;

  logic                   cap_tgl;
  logic [SYNC_N-1:0]      sync1_q;
  logic [SYNC_N-1:0]      sync2_q;
  logic [SYNC_N-1:0]      pins_raw;
  logic                   tgl_seen_q;
  logic                   mon_evt;
  logic                   cs_s;
  logic                   inh_s;
  logic                   lk_s;
  logic                   aux_s;
  logic [3:0]             op;
  logic [1:0]             idx;
  logic [ssm_pkg::ADC_W-1:0] val;
  logic                   cmd_evt;
  logic                   scrap_cmd;
  logic                   mon_crash;
  logic                   ana_crash;
  logic                   crash;
  logic [ssm_pkg::ADC_W-1:0] thr_q [ssm_pkg::SRC_N];
  logic [ssm_pkg::ADC_W-1:0] athr_q;
  logic [FILT_W-1:0]      filt_q;
  logic [15:0]            reply_q;
  logic [15:0]            su_cnt_q;
  logic [31:0]            dwell_q;

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock domain
  ssm_spi_monitor u_mon (
    .spi_sck_i   (spi_sck_i),
    .sys_rst_i   (sys_rst_i),
    .spi_cs_n_i  (spi_cs_n_i),
    .mon_cs_n_i  (mon_cs_n_i),
    .spi_si_i    (spi_si_i),
    .mon_miso_i  (mon_miso_i),
    .reply_i     (reply_q),
    .spi_so_o    (spi_so_o),
    .spi_so_oe_o (spi_so_oe_o),
    .cap_o       (cap),
    .cap_tgl_o   (cap_tgl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for pins and the capture toggle
  assign pins_raw = {aux_comm_line_i, arm_lockout_i, self_test_inhibit_i, spi_cs_n_i, cap_tgl};

  for (genvar i = 0; i < SYNC_N; i++) begin : g_sync
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        sync1_q[i] <= 1'b0;
        sync2_q[i] <= 1'b0;
      end else begin
        sync1_q[i] <= pins_raw[i];
        sync2_q[i] <= sync1_q[i];
      end
    end
  end

  assign cs_s  = sync2_q[1];
  assign inh_s = sync2_q[2];
  assign lk_s  = sync2_q[3];
  assign aux_s = sync2_q[4];

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tgl_seen_q <= 1'b0;
    end else begin
      tgl_seen_q <= sync2_q[0];
    end
  end

  assign mon_evt = sync2_q[0] ^ tgl_seen_q;

  ////////////////////////////////////////////////////////////////////////////
  // Word decode and threshold compare
  assign op        = cap.data[ssm_pkg::OP_MSB:ssm_pkg::OP_LSB];
  assign idx       = cap.data[ssm_pkg::IDX_MSB:ssm_pkg::IDX_LSB];
  assign val       = cap.data[ssm_pkg::DAT_MSB:0];
  assign cmd_evt   = mon_evt && (cap.src == 2'h0);
  assign scrap_cmd = cmd_evt && (op == ssm_pkg::OP_SCRAP);

  always_comb begin
    mon_crash = 1'b0;
    if (cmd_evt && op == ssm_pkg::OP_SAT_DATA) begin
      mon_crash = val > thr_q[0];
    end else if (mon_evt && cap.src != 2'h0 && cap.data[ssm_pkg::VALID_BIT]) begin
      mon_crash = val > thr_q[cap.src];
    end
  end

  assign ana_crash = !inh_s && (analog_hold_o > athr_q);
  assign crash     = mon_crash || ana_crash;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < ssm_pkg::SRC_N; i++) begin
        thr_q[i] <= ssm_pkg::THR_RST;
      end
      athr_q <= ssm_pkg::THR_RST;
    end else if (cmd_evt && op == ssm_pkg::OP_SET_THR) begin
      thr_q[idx] <= val;
    end else if (cmd_evt && op == ssm_pkg::OP_SET_ATHR) begin
      athr_q <= val;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog filter and holding register
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      filt_q        <= '0;
      analog_hold_o <= '0;
    end else if (adc_valid_i && !inh_s) begin
      filt_q        <= filt_q - (filt_q >> ssm_pkg::FILT_FRAC) + {2'h0, adc_data_i};
      analog_hold_o <= filt_q[FILT_W-1:ssm_pkg::FILT_FRAC];
    end
  end

  // Reply snapshot frozen while the main select is low
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reply_q <= 16'h0000;
    end else if (cs_s) begin
      reply_q <= {state_q, inh_s, 2'h0, analog_hold_o};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Safing state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      ssm_pkg::ST_STARTUP: begin
        if (su_cnt_q == SU_LAST) begin
          state_d = ssm_pkg::ST_IDLE;
        end
      end
      ssm_pkg::ST_IDLE: begin
        if (scrap_cmd) begin
          state_d = ssm_pkg::ST_SCRAP_HS;
        end else if (crash) begin
          state_d = ssm_pkg::ST_ARMED;
        end
      end
      ssm_pkg::ST_ARMED: begin
        if (scrap_cmd) begin
          state_d = ssm_pkg::ST_SCRAP_HS;
        end else if (!crash && dwell_q == 32'h0) begin
          state_d = ssm_pkg::ST_IDLE;
        end
      end
      ssm_pkg::ST_LOCKOUT: begin
        if (!lk_s) begin
          state_d = ssm_pkg::ST_IDLE;
        end
      end
      ssm_pkg::ST_SCRAP_HS: begin
        state_d = aux_s ? ssm_pkg::ST_SCRAP : ssm_pkg::ST_IDLE;
      end
      ssm_pkg::ST_SCRAP: begin
        if (!aux_s) begin
          state_d = ssm_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = ssm_pkg::ST_STARTUP;
      end
    endcase
    if (lk_s && state_q != ssm_pkg::ST_STARTUP) begin
      state_d = ssm_pkg::ST_LOCKOUT;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= ssm_pkg::ST_STARTUP;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      su_cnt_q <= 16'h0000;
    end else if (state_q == ssm_pkg::ST_STARTUP && su_cnt_q != SU_LAST) begin
      su_cnt_q <= su_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dwell_q <= 32'h0;
    end else if (crash) begin
      dwell_q <= DWELL_LD;
    end else if (dwell_q != 32'h0) begin
      dwell_q <= dwell_q - 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arming outputs
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fire_enable_o         <= 1'b0;
      fire_inhibit_out_o    <= 1'b1;
      fire_enable_oe_o      <= 1'b0;
      fire_inhibit_out_oe_o <= 1'b0;
    end else begin
      fire_enable_o         <= state_q == ssm_pkg::ST_ARMED || state_q == ssm_pkg::ST_SCRAP;
      fire_inhibit_out_o    <= !(state_q == ssm_pkg::ST_ARMED || state_q == ssm_pkg::ST_SCRAP);
      fire_enable_oe_o      <= state_q != ssm_pkg::ST_STARTUP && state_q != ssm_pkg::ST_LOCKOUT;
      fire_inhibit_out_oe_o <= state_q != ssm_pkg::ST_STARTUP && state_q != ssm_pkg::ST_LOCKOUT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  a_fire_opposite: assert property (fire_enable_o != fire_inhibit_out_o)
    else $error("fire outputs not complementary");

  a_oe_pair: assert property (fire_enable_oe_o == fire_inhibit_out_oe_o)
    else $error("fire output enables differ");

  a_hiz_startup: assert property ((state_q == ssm_pkg::ST_STARTUP) |=> !fire_enable_oe_o)
    else $error("fire outputs driven in start-up");

  a_hiz_lockout: assert property ((lk_s && state_q != ssm_pkg::ST_STARTUP) |=> ##1 !fire_inhibit_out_oe_o)
    else $error("fire outputs driven in lockout");

  a_inh_freeze: assert property (inh_s |=> $stable(filt_q) && $stable(analog_hold_o))
    else $error("filter moved under self-test inhibit");

  a_hold_load: assert property ((adc_valid_i && !inh_s) |=> analog_hold_o == $past(filt_q[FILT_W-1:2]))
    else $error("holding register not loaded");

  a_scrap_enter: assert property ((state_q == ssm_pkg::ST_SCRAP_HS && aux_s && !lk_s)
    |=> state_q == ssm_pkg::ST_SCRAP)
    else $error("scrap not entered on aux high");

  a_scrap_leave: assert property ((state_q == ssm_pkg::ST_SCRAP_HS && !aux_s && !lk_s)
    |=> state_q == ssm_pkg::ST_IDLE)
    else $error("scrap not left on aux low");

  a_crash_arm: assert property ((state_q == ssm_pkg::ST_IDLE && crash && !lk_s && !scrap_cmd)
    |=> state_q == ssm_pkg::ST_ARMED ##1 (fire_enable_o && fire_enable_oe_o))
    else $error("crash did not arm");

  a_mon_thr: assert property ((mon_evt && cap.src != 2'h0 && cap.data[ssm_pkg::VALID_BIT] && !lk_s
    && val > thr_q[cap.src] && (state_q == ssm_pkg::ST_IDLE || state_q == ssm_pkg::ST_ARMED))
    |=> state_q == ssm_pkg::ST_ARMED)
    else $error("monitored sample above threshold missed");

endmodule

// ==== ssm_pkg.sv ====
// Shared constants, states and carrier types for the safing front end
package ssm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_PERIOD_NS     = 25;
  localparam int unsigned STARTUP_TIME_NS   = 10000;
  localparam int unsigned STARTUP_CYC       = (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ARM_DWELL_TIME_US = 1000;
  localparam int unsigned ARM_DWELL_CYC_DEF = (ARM_DWELL_TIME_US * 1000) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and serial word fields
  localparam int unsigned ADC_W     = 10;
  localparam int unsigned WORD_W    = 16;
  localparam int unsigned SRC_N     = 4;
  localparam int unsigned OP_MSB    = 15;
  localparam int unsigned OP_LSB    = 12;
  localparam int unsigned IDX_MSB   = 11;
  localparam int unsigned IDX_LSB   = 10;
  localparam int unsigned DAT_MSB   = 9;
  localparam int unsigned VALID_BIT = 15;
  localparam int unsigned FILT_FRAC = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Host command opcodes on the main select
  localparam logic [3:0] OP_SAT_DATA = 4'h1;
  localparam logic [3:0] OP_SET_THR  = 4'h2;
  localparam logic [3:0] OP_SCRAP    = 4'h3;
  localparam logic [3:0] OP_SET_ATHR = 4'h4;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [ADC_W-1:0] THR_RST = 10'h3FF;

  ////////////////////////////////////////////////////////////////////////////
  // Safing states
  typedef enum logic [2:0] {
    ST_STARTUP = 3'b000,
    ST_IDLE    = 3'b001,
    ST_ARMED   = 3'b010,
    ST_LOCKOUT = 3'b011,
    ST_SCRAP_HS = 3'b100,
    ST_SCRAP   = 3'b101
  } ssm_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // One captured serial word and its source
  typedef struct packed {
    logic [1:0]        src;
    logic [WORD_W-1:0] data;
  } ssm_mon_word_t;

endpackage

// ==== ssm_spi_monitor.sv ====
// Serial clock domain: passive word capture on all selects and reply shifter
module ssm_spi_monitor (
  // Link clock and reset
  input  wire logic                  spi_sck_i,
  input  wire logic                  sys_rst_i,
  // Bus lines
  input  wire logic                  spi_cs_n_i,
  input  wire logic [2:0]            mon_cs_n_i,
  input  wire logic                  spi_si_i,
  input  wire logic                  mon_miso_i,
  // Reply and capture
  input  wire logic [15:0]           reply_i,
  output logic                       spi_so_o,
  output logic                       spi_so_oe_o,
  output ssm_pkg::ssm_mon_word_t     cap_o,
  output logic                       cap_tgl_o
);

  logic       frame_rst;
  logic       so_rst;
  logic       din;
  logic [1:0] src;
  logic [4:0] bit_cnt_q;
  logic [14:0] shift_q;
  logic [4:0] so_cnt_q;

  assign frame_rst = sys_rst_i | (spi_cs_n_i & (&mon_cs_n_i));
  assign so_rst    = sys_rst_i | spi_cs_n_i;

  ////////////////////////////////////////////////////////////////////////////
  // Source select, main select first
  always_comb begin
    din = mon_miso_i;
    src = 2'h3;
    if (!spi_cs_n_i) begin
      din = spi_si_i;
      src = 2'h0;
    end else if (!mon_cs_n_i[0]) begin
      src = 2'h1;
    end else if (!mon_cs_n_i[1]) begin
      src = 2'h2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sampling on falling edges, frame state cleared by deselect
  always_ff @(negedge spi_sck_i or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt_q <= 5'h00;
      shift_q   <= 15'h0000;
    end else if (bit_cnt_q != 5'h10) begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
      shift_q   <= {shift_q[13:0], din};
    end
  end

  always_ff @(negedge spi_sck_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cap_o     <= '0;
      cap_tgl_o <= 1'b0;
    end else if (!frame_rst && bit_cnt_q == 5'h0F) begin
      cap_o.data <= {shift_q, din};
      cap_o.src  <= src;
      cap_tgl_o  <= ~cap_tgl_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reply shifts out on rising edges, main select only
  always_ff @(posedge spi_sck_i or posedge so_rst) begin
    if (so_rst) begin
      so_cnt_q    <= 5'h00;
      spi_so_o    <= 1'b0;
      spi_so_oe_o <= 1'b0;
    end else begin
      spi_so_oe_o <= 1'b1;
      if (so_cnt_q != 5'h10) begin
        so_cnt_q <= so_cnt_q + 5'h01;
        spi_so_o <= reply_i[4'hF - so_cnt_q[3:0]];
      end else begin
        spi_so_o <= 1'b0;
      end
    end
  end

  a_so_quiet: assert property (@(negedge spi_sck_i) disable iff (sys_rst_i)
    spi_cs_n_i |-> !spi_so_oe_o)
    else $error("reply driven without main select");

endmodule

// ==== ssm_host_model.sv ====
// Host controller and sensor model that drive the serial bus from its far side
module ssm_host_model (
  // Bus lines
  output logic       spi_sck_o,
  output logic       spi_cs_n_o,
  output logic [2:0] mon_cs_n_o,
  output logic       spi_si_o,
  output logic       mon_miso_o,
  // Reply from the device
  input  wire logic  spi_so_i,
  input  wire logic  spi_so_oe_i
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam time HALF = 6ns;

  logic oe_seen;

  initial begin
    spi_sck_o  = 1'b0;
    spi_cs_n_o = 1'b1;
    mon_cs_n_o = 3'h7;
    spi_si_o   = 1'b0;
    mon_miso_o = 1'b0;
    oe_seen    = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One 16-bit frame; source 0 is the main select, 1 to 3 the monitor selects
  task automatic frame(input logic [1:0] src, input logic [15:0] word, output logic [15:0] rdata);
    rdata   = 16'h0000;
    oe_seen = 1'b0;
    if (src == 2'h0) begin
      spi_cs_n_o = 1'b0;
    end else begin
      mon_cs_n_o[src - 2'h1] = 1'b0;
    end
    #HALF;
    for (int i = 15; i >= 0; i--) begin
      spi_sck_o = 1'b1;
      #1ns;
      if (src == 2'h0) begin
        spi_si_o = word[i];
      end else begin
        mon_miso_o = word[i];
      end
      #(HALF - 1ns);
      spi_sck_o = 1'b0;
      rdata[i]  = spi_so_i;
      oe_seen   = oe_seen | spi_so_oe_i;
      #HALF;
    end
    spi_cs_n_o = 1'b1;
    mon_cs_n_o = 3'h7;
    // Released lines do not keep their last value
    spi_si_o   = ~spi_si_o;
    mon_miso_o = ~mon_miso_o;
    #(HALF * 40);
  endtask

endmodule

// ==== test_safing_spi_monitor_arming.sv ====
// Self-checking bench for the safing front end
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin errors++; \
  $display("FAIL at %0t: got %h expected %h", $time, (got), (exp)); end end

module test_safing_spi_monitor_arming;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [9:0] smp;
    logic       inh;
    logic [9:0] hold;
  } ssm_row_t;

  logic       clk_sys_i, sys_rst_i, adc_valid, inhibit, lockout, aux;
  logic       sck, cs_n, si, miso, so, so_oe;
  logic [2:0] mon_cs_n;
  logic [9:0] adc_data, hold;
  logic       fe, fe_oe, fi, fi_oe;
  logic [15:0] rd;
  int         errors, checks, cycles;
  ssm_row_t   rows [5] = '{'{10'h100, 1'b0, 10'h000}, '{10'h100, 1'b0, 10'h040},
                           '{10'h3FF, 1'b1, 10'h040}, '{10'h3FF, 1'b0, 10'h070},
                           '{10'h000, 1'b0, 10'h153}};

  ssm_safing_top #(.ARM_DWELL_CYC(20)) i_dut (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .spi_sck_i(sck), .spi_cs_n_i(cs_n),
    .mon_cs_n_i(mon_cs_n), .spi_si_i(si), .mon_miso_i(miso), .spi_so_o(so), .spi_so_oe_o(so_oe),
    .adc_data_i(adc_data), .adc_valid_i(adc_valid), .self_test_inhibit_i(inhibit),
    .arm_lockout_i(lockout), .aux_comm_line_i(aux), .fire_enable_o(fe), .fire_enable_oe_o(fe_oe),
    .fire_inhibit_out_o(fi), .fire_inhibit_out_oe_o(fi_oe), .analog_hold_o(hold)
  );

  ssm_host_model i_host (
    .spi_sck_o(sck), .spi_cs_n_o(cs_n), .mon_cs_n_o(mon_cs_n), .spi_si_o(si),
    .mon_miso_o(miso), .spi_so_i(so), .spi_so_oe_i(so_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timeout
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5ns clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic give_verdict();
    if (errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1ns;
  endtask

  task automatic send(input logic [1:0] src, input logic [15:0] word);
    i_host.frame(src, word, rd);
    `CHK(i_host.oe_seen, src == 2'h0)
  endtask

  task automatic fire_chk(input logic en);
    `CHK(fe, en)
    `CHK(fi, ~en)
    `CHK(fe_oe & fi_oe, 1'b1)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    sys_rst_i = 1'b1;
    adc_valid = 1'b0;
    adc_data  = 10'h000;
    inhibit   = 1'b0;
    lockout   = 1'b0;
    aux       = 1'b0;
    cyc(5);
    `CHK({fe_oe, fi_oe, fe, fi, hold}, {4'h1, 10'h000})
    @(posedge clk_sys_i) sys_rst_i <= 1'b0;
    cyc(100);
    `CHK(fe_oe | fi_oe, 1'b0)
    cyc(320);
    fire_chk(1'b0);
    // Analog filter and holding register
    foreach (rows[k]) begin
      @(posedge clk_sys_i) inhibit <= rows[k].inh;
      cyc(4);
      @(posedge clk_sys_i) begin
        adc_data  <= rows[k].smp;
        adc_valid <= 1'b1;
      end
      @(posedge clk_sys_i) adc_valid <= 1'b0;
      cyc(4);
      `CHK(hold, rows[k].hold)
    end
    send(2'h0, 16'h0000);
    send(2'h0, 16'h0000);
    `CHK(rd, {ssm_pkg::ST_IDLE, 3'h0, 10'h153})
    // Satellite data on the main select, equal value first
    send(2'h0, 16'h2100);
    send(2'h0, 16'h1100);
    cyc(1);
    fire_chk(1'b0);
    send(2'h0, 16'h1101);
    cyc(1);
    fire_chk(1'b1);
    cyc(40);
    fire_chk(1'b0);
    // Monitor selects, each bound to its own threshold
    for (int s = 3; s >= 1; s--) begin
      send(2'h0, {4'h2, s[1:0], 10'h050});
      if (s > 1) begin
        send(s[1:0] - 2'h1, 16'h8051);
        cyc(1);
        fire_chk(1'b0);
      end
      send(s[1:0], 16'h0051);
      cyc(1);
      fire_chk(1'b0);
      send(s[1:0], 16'h8051);
      cyc(1);
      fire_chk(1'b1);
      cyc(40);
    end
    // Scrap handshake decided by the aux line
    send(2'h0, 16'h3000);
    cyc(1);
    fire_chk(1'b0);
    @(posedge clk_sys_i) aux <= 1'b1;
    cyc(4);
    send(2'h0, 16'h3000);
    cyc(1);
    fire_chk(1'b1);
    @(posedge clk_sys_i) aux <= 1'b0;
    cyc(6);
    fire_chk(1'b0);
    // Lockout floats both outputs
    @(posedge clk_sys_i) lockout <= 1'b1;
    cyc(5);
    `CHK(fe_oe | fi_oe, 1'b0)
    @(posedge clk_sys_i) lockout <= 1'b0;
    cyc(5);
    fire_chk(1'b0);
    // Analog threshold arms, self-test inhibit masks it
    send(2'h0, 16'h4150);
    cyc(1);
    fire_chk(1'b1);
    @(posedge clk_sys_i) inhibit <= 1'b1;
    cyc(30);
    fire_chk(1'b0);
    `CHK(hold, 10'h153)
    @(posedge clk_sys_i) inhibit <= 1'b0;
    cyc(6);
    fire_chk(1'b1);
    send(2'h0, 16'h43FF);
    cyc(30);
    fire_chk(1'b0);
    // Reset in mid-run while armed
    send(2'h0, 16'h1101);
    cyc(1);
    fire_chk(1'b1);
    @(posedge clk_sys_i) sys_rst_i <= 1'b1;
    #1ns;
    `CHK(fe_oe | fi_oe, 1'b0)
    cyc(3);
    @(posedge clk_sys_i) sys_rst_i <= 1'b0;
    cyc(10);
    `CHK(fe_oe | fi_oe, 1'b0)
    give_verdict();
  end

endmodule
